// file: ppf_pkg.sv
// Shared constants and types for the power-to-pulse frequency converter
package ppf_pkg;

    // Oscillator rate
    localparam int unsigned CLK_MHZ           = 100;

    // Slow outputs: width turns to half period below this period
    localparam int unsigned SLOW_HALF_LIMIT_MS = 1100;
    // Calibration output: nominal width and half-period limit
    localparam int unsigned CAL_WIDTH_MS       = 180;
    localparam int unsigned CAL_HALF_LIMIT_MS  = 360;
    // Calibration width in the 2048x mode
    localparam int unsigned CAL_FAST_WIDTH_US  = 36;

    // Derived cycle counts (longest times, rounded down)
    localparam int unsigned SLOW_WIDTH_CYC_DEF = (SLOW_HALF_LIMIT_MS / 2) * 1000 * CLK_MHZ;
    localparam int unsigned CAL_WIDTH_CYC_DEF  = CAL_WIDTH_MS * 1000 * CLK_MHZ;
    localparam int unsigned CAL_FAST_CYC       = CAL_FAST_WIDTH_US * CLK_MHZ;

    // Datapath sizing
    localparam int unsigned PWR_W_DEF          = 16;
    localparam int unsigned QUANT_LOG2_DEF     = 30;
    localparam int unsigned SAMPLE_DIV_LOG2_DEF = 10;
    localparam int unsigned CNT_W              = 32;

    // Calibration scale exponents (scale = 2**shift)
    localparam logic [3:0]  CAL_SHIFT_128      = 4'h7;
    localparam logic [3:0]  CAL_SHIFT_64       = 4'h6;
    localparam logic [3:0]  CAL_SHIFT_32       = 4'h5;
    localparam logic [3:0]  CAL_SHIFT_16       = 4'h4;
    localparam logic [3:0]  CAL_SHIFT_2048     = 4'hb;
    localparam logic [1:0]  RATE_CODE_FAST     = 2'h3;

    // Pin selections travel together
    typedef struct packed {
        logic       scale_sel;
        logic [1:0] rate_code;
    } ppf_sel_s;

endpackage

// file: ppf_converter.sv
// Power-to-pulse frequency converter: accumulators, pulse shapers, outputs
module ppf_converter
    import ppf_pkg::*;
#(
    parameter int unsigned PWR_W           = PWR_W_DEF,
    parameter int unsigned QUANT_LOG2      = QUANT_LOG2_DEF,
    parameter int unsigned SAMPLE_DIV_LOG2 = SAMPLE_DIV_LOG2_DEF,
    parameter int unsigned SLOW_WIDTH_CYC  = SLOW_WIDTH_CYC_DEF,
    parameter int unsigned CAL_WIDTH_CYC   = CAL_WIDTH_CYC_DEF
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [PWR_W-1:0] power_word_in,
    input  wire logic             rate_select_high_in,
    input  wire logic             rate_select_low_in,
    input  wire logic             calib_scale_select_in,
    output logic                  slow_pulse_out_a_out,
    output logic                  slow_pulse_out_b_out,
    output logic                  calib_pulse_out_out
);

    localparam int unsigned ACC_W = QUANT_LOG2 + 1;
    localparam logic [ACC_W-1:0] SLOW_Q = ACC_W'(1) << QUANT_LOG2;

    // Pin synchronisers: two stages before any use
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    ppf_sel_s   sel;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_meta <= 3'h0;
            sel_sync <= 3'h0;
        end else begin
            sel_meta <= {calib_scale_select_in, rate_select_high_in, rate_select_low_in};
            sel_sync <= sel_meta;
        end
    end

    assign sel = ppf_sel_s'(sel_sync);

    // Base tick from a power-of-two prescaler; no fractional divide
    logic [SAMPLE_DIV_LOG2-1:0] prescale;
    wire  base_tick = &prescale;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    // Each select step doubles the increment, i.e. doubles the base rate
    wire [ACC_W-1:0] inc = ACC_W'(power_word_in) << sel.rate_code;

    // Calibration scale lookup
    wire fast_mode = !sel.scale_sel && (sel.rate_code == RATE_CODE_FAST);
    logic [3:0] cal_shift;

    always_comb begin
        unique case (sel.rate_code)
            2'h0:    cal_shift = sel.scale_sel ? CAL_SHIFT_128 : CAL_SHIFT_64;
            2'h1:    cal_shift = sel.scale_sel ? CAL_SHIFT_64 : CAL_SHIFT_32;
            2'h2:    cal_shift = sel.scale_sel ? CAL_SHIFT_32 : CAL_SHIFT_16;
            2'h3:    cal_shift = sel.scale_sel ? CAL_SHIFT_16 : CAL_SHIFT_2048;
        endcase
    end

    // Quantum is sized so one increment never spans two quanta
    wire [ACC_W-1:0] cal_q = SLOW_Q >> cal_shift;

    // Energy accumulators
    logic [ACC_W-1:0] slow_acc;
    logic [ACC_W-1:0] cal_acc;
    wire  [ACC_W-1:0] slow_sum = slow_acc + inc;
    wire  [ACC_W-1:0] cal_sum  = cal_acc + inc;
    wire  slow_evt = base_tick && (slow_sum >= SLOW_Q);
    wire  cal_evt  = base_tick && (cal_sum >= cal_q);
    wire  [ACC_W-1:0] next_slow_acc = slow_evt ? slow_sum - SLOW_Q : slow_sum;
    wire  [ACC_W-1:0] next_cal_acc  = cal_evt ? cal_sum - cal_q : cal_sum;

    // Remainder carries over, so ripple averages out between pulses
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slow_acc <= '0;
            cal_acc  <= '0;
        end else if (base_tick) begin
            slow_acc <= next_slow_acc;
            cal_acc  <= (cal_q > cal_acc) ? next_cal_acc : '0; // Scale change drops stale energy
        end
    end

    // Pulse shapers: index 0 slow pair, index 1 calibration
    logic [CNT_W-1:0] per_cnt [2];
    logic [CNT_W-1:0] wid_cnt [2];
    logic [CNT_W-1:0] next_wid [2];
    logic [1:0]       evt;
    logic [CNT_W-1:0] wmax [2];

    assign evt     = {cal_evt, slow_evt};
    assign wmax[0] = CNT_W'(SLOW_WIDTH_CYC);
    assign wmax[1] = fast_mode ? CNT_W'(CAL_FAST_CYC) : CNT_W'(CAL_WIDTH_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_shape
            // Width shrinks to half the period just ended; fast mode keeps the calibration width fixed
            wire [CNT_W-1:0] half_per = per_cnt[gi] >> 1;
            wire use_half = (gi == 0 || !fast_mode) && (half_per < wmax[gi]);
            wire [CNT_W-1:0] w_raw = use_half ? half_per : wmax[gi];
            wire [CNT_W-1:0] w_load = (w_raw == '0) ? CNT_W'(1) : w_raw;

            assign next_wid[gi] = evt[gi] ? w_load :
                                  (wid_cnt[gi] != '0) ? wid_cnt[gi] - 1'b1 : '0;

            // Period counter saturates, so the first pulse gets full width
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    per_cnt[gi] <= '1;
                    wid_cnt[gi] <= '0;
                end else begin
                    per_cnt[gi] <= evt[gi] ? CNT_W'(1) :
                                   (&per_cnt[gi]) ? per_cnt[gi] : per_cnt[gi] + 1'b1;
                    wid_cnt[gi] <= next_wid[gi];
                end
            end
        end
    endgenerate

    // Slow pulses alternate between the two outputs; phase low means A goes next
    logic phase;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            phase <= 1'b0;
        else if (slow_evt)
            phase <= ~phase;
    end

    // Registered outputs; slow pair rests high, calibration rests low
    wire next_slow_on = next_wid[0] != '0;
    wire next_phase   = slow_evt ? ~phase : phase;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slow_pulse_out_a_out <= 1'b1;
            slow_pulse_out_b_out <= 1'b1;
            calib_pulse_out_out  <= 1'b0;
        end else begin
            // Owner of a running pulse is the output after the toggle
            slow_pulse_out_a_out <= !(next_slow_on && next_phase);
            slow_pulse_out_b_out <= !(next_slow_on && !next_phase);
            calib_pulse_out_out  <= next_wid[1] != '0;
        end
    end

    // Checks
    a_slow_never_both: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        slow_pulse_out_a_out || slow_pulse_out_b_out)
        else $error("both slow outputs low");

    a_slow_event_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        slow_evt |=> (!slow_pulse_out_a_out ^ !slow_pulse_out_b_out))
        else $error("slow event gave no low pulse");

    a_slow_alternate: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        slow_evt |=> (!slow_pulse_out_a_out == $past(phase)) == 1'b0)
        else $error("slow outputs did not alternate");

    a_cal_event_high: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cal_evt |=> calib_pulse_out_out)
        else $error("calibration event gave no pulse");

    a_cal_fast_width: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cal_evt && fast_mode) |=> wid_cnt[1] == CNT_W'(CAL_FAST_CYC))
        else $error("fast calibration width wrong");

    a_cal_width_cap: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (calib_pulse_out_out && !fast_mode) |-> wid_cnt[1] <= CNT_W'(CAL_WIDTH_CYC))
        else $error("calibration width above limit");

    a_slow_width_half: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (slow_evt && per_cnt[0] > 32'h1) |=> wid_cnt[0] <= ($past(per_cnt[0]) >> 1))
        else $error("slow width above half period");

    a_slow_idle_high: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!slow_evt && wid_cnt[0] <= 32'h1) |=> (slow_pulse_out_a_out && slow_pulse_out_b_out))
        else $error("slow output left low after pulse");

    a_cal_idle_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!cal_evt && wid_cnt[1] <= 32'h1) |=> !calib_pulse_out_out)
        else $error("calibration output left high after pulse");

    a_scale_fast_map: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        fast_mode |-> cal_q == (SLOW_Q >> 11))
        else $error("2048x quantum wrong");

    a_acc_below_quantum: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        ##1 slow_acc < SLOW_Q)
        else $error("slow accumulator holds a whole quantum");

    c_slow_pulse: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        slow_evt ##1 !slow_pulse_out_a_out);
    c_slow_pair: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (slow_evt && phase) ##1 !slow_pulse_out_b_out);
    c_cal_nominal: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cal_evt && !fast_mode);
    c_cal_fast: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cal_evt && fast_mode);

endmodule

// file: ppf_pulse_counter.sv
// Pulse counter model that stands at the converter's three outputs
module ppf_pulse_counter (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        slow_a_in,
    input  wire logic        slow_b_in,
    input  wire logic        cal_in,
    output logic [31:0]      n_slow_out,
    output logic [31:0]      n_cal_out,
    output logic [31:0]      n_bad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_a;
    logic prev_b;
    logic prev_cal;
    logic last_b;
    // Free-running edge counts; no own timer, so the reader allows one pulse of slack
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_a     <= 1'b1;
            prev_b     <= 1'b1;
            prev_cal   <= 1'b0;
            last_b     <= 1'b1;
            n_slow_out <= '0;
            n_cal_out  <= '0;
            n_bad_out  <= '0;
        end else begin
            prev_a   <= slow_a_in;
            prev_b   <= slow_b_in;
            prev_cal <= cal_in;
            if (!prev_cal && cal_in) begin
                n_cal_out <= n_cal_out + 1;
            end
            if (prev_a && !slow_a_in) begin
                n_slow_out <= n_slow_out + 1;
                last_b     <= 1'b0;
                n_bad_out  <= n_bad_out + 32'(!last_b || !slow_b_in);
            end else if (prev_b && !slow_b_in) begin
                n_slow_out <= n_slow_out + 1;
                last_b     <= 1'b1;
                n_bad_out  <= n_bad_out + 32'(last_b || !slow_a_in);
            end
        end
    end
endmodule

// file: test_power_to_pulse_frequency_converter.sv
// Self-checking bench for the power-to-pulse frequency converter
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module test_power_to_pulse_frequency_converter;
    timeunit 1ns;
    timeprecision 1ps;
    import ppf_pkg::*;
    localparam int QL  = 20;
    localparam int WIN = 16000; // Shortened counting window
    logic        ref_clk_in;
    logic        rst_b_in;
    logic [5:0]  power;
    ppf_sel_s    sel;
    logic        slow_a;
    logic        slow_b;
    logic        cal;
    logic [31:0] n_slow;
    logic [31:0] n_cal;
    logic [31:0] n_bad;
    int          n_fail  = 0;
    int          checked = 0;
    int          seed    = 62;
    int          w;
    int          e;
    time         t_on;
    time         t_a;
    int          shifts [8] = '{6, 5, 4, 11, 7, 6, 5, 4};
    wire logic [2:0] act = {~slow_b, ~slow_a, cal};

    ppf_converter #(.PWR_W(6), .QUANT_LOG2(QL), .SAMPLE_DIV_LOG2(2), .SLOW_WIDTH_CYC(20),
                    .CAL_WIDTH_CYC(10)) dut (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .power_word_in(power),
        .rate_select_high_in(sel.rate_code[1]), .rate_select_low_in(sel.rate_code[0]),
        .calib_scale_select_in(sel.scale_sel), .slow_pulse_out_a_out(slow_a),
        .slow_pulse_out_b_out(slow_b), .calib_pulse_out_out(cal));
    ppf_pulse_counter counter (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .slow_a_in(slow_a),
        .slow_b_in(slow_b), .cal_in(cal), .n_slow_out(n_slow), .n_cal_out(n_cal),
        .n_bad_out(n_bad));

    // 100 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic close_out();
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // Count may lag or lead by one pulse, since ticks and window are not aligned
    function automatic logic near(input logic [31:0] g, input int x);
        return (g + 1 >= x) && (g <= x + 1);
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic do_reset();
        rst_b_in = 1'b0;
        step(8);
        `CHK({slow_a, slow_b, cal}, 3'b110);
        rst_b_in = 1'b1;
    endtask

    // Wait for a pulse on one output, optionally starve the power, then time it
    task automatic width_of(input int which, input logic zero, output int wd);
        int k;
        wd = 0;
        for (k = 0; k < 20000 && !act[which]; k++) step(1);
        if (k == 20000) begin
            n_fail++;
            close_out();
        end
        t_on = $time; // Pulse start, kept for spacing checks
        if (zero) power = '0;
        while (act[which] && wd < 20000) begin
            wd++;
            step(1);
        end
    endtask

    initial begin
        rst_b_in = 1'b0;
        power    = '0;
        sel      = '0;
        // Random load at every select code, counted over a fixed window
        for (int c = 0; c < 4; c++) begin
            power = 6'(32 + ($random(seed) & 31));
            sel.rate_code = 2'(c);
            sel.scale_sel = (c == 3) ? 1'b1 : 1'($random(seed));
            do_reset();
            step(WIN);
            e = (WIN / 4) * (int'(power) << c);
            `CHK(near(n_slow, e >> QL), 1'b1);
            `CHK(near(n_cal, e >> (QL - shifts[sel])), 1'b1);
            `CHK(n_bad, 0);
        end
        // Full load: slow A then slow B, each at full width
        power = 6'h3f;
        sel   = 3'b111;
        do_reset();
        width_of(1, 1'b0, w);
        t_a = t_on;
        `CHK(w, 20);
        width_of(2, 1'b1, w);
        `CHK(w, 20);
        // A-to-B spacing in base ticks (40 ns each) against quantum over full-load step
        `CHK(near(32'((t_on - t_a) / 40), (1 << QL) / (63 << 3)), 1'b1);
        `CHK(n_bad, 0);
        // Calibration pulse at nominal width, then in the 2048x mode
        power = 6'h3f;
        sel   = 3'b100;
        do_reset();
        width_of(0, 1'b1, w);
        `CHK(w, 10);
        power = 6'h3f;
        sel   = 3'b011;
        do_reset();
        width_of(0, 1'b1, w);
        `CHK(w, CAL_FAST_CYC);
        close_out();
    end
endmodule
